// file: verilog/boot_stream_map.svh
// Constants for the boot-stream and sector relock command logic.
// Assumes inclusion by bare name from files that also import boot_stream_pkg.
`ifndef BOOT_STREAM_MAP_SVH
`define BOOT_STREAM_MAP_SVH

// =====================================================================
// Opcodes
`define OP_WRITE_ENABLE   8'h06
`define OP_READ_STATUS    8'h05
`define OP_BOOT_CFG_READ  8'h14
`define OP_BOOT_CFG_WRITE 8'h15
`define OP_SECTOR_RELOCK  8'h24
`define OP_SECTOR_UNPROT  8'h26

// =====================================================================
// Boot configuration register fields and reset value
`define CFG_EN_BIT        0
`define CFG_DLY_LSB       1
`define CFG_DLY_MSB       4
`define CFG_ADDR_LSB      8
`define CFG_ADDR_MSB      31
`define CFG_RESET         32'h0000_0000
`define CFG_BITS          6'h20

// =====================================================================
// Status byte fields and address split
`define SR_WIP_BIT        0
`define SR_WEL_BIT        1
`define SR_QE_BIT         6
`define SECTOR_LSB        12
`define UNPROT_LAST_BIT   6'h17

// =====================================================================
// Timing
`define CLK_PERIOD_NS     50
`define CFG_WR_TIME_NS    100000

`endif

// file: verilog/boot_stream_pkg.sv
// Types shared by the boot-stream command logic and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package boot_stream_pkg;

  // One-hot states of the serial command interpreter.
  typedef enum logic [9:0] {
    ST_LOAD     = 10'h001,
    ST_IDLE     = 10'h002,
    ST_BOOT_DLY = 10'h004,
    ST_BOOT_OUT = 10'h008,
    ST_CMD      = 10'h010,
    ST_RD_CFG   = 10'h020,
    ST_RD_STAT  = 10'h040,
    ST_WR_CFG   = 10'h080,
    ST_UNPROT   = 10'h100,
    ST_SKIP     = 10'h200
  } state_e;

  typedef logic [31:0] cfg_t;

endpackage

// file: verilog/byte_fifo_if.sv
// Carrier between the command logic and its boot data FIFO.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface byte_fifo_if #(parameter int WIDTH = 8);
  logic             push_valid;
  logic             push_ready;
  logic [WIDTH-1:0] push_data;
  logic             pop_valid;
  logic             pop_ready;
  logic [WIDTH-1:0] pop_data;
  logic             flush;
  modport user  (output push_valid, push_data, pop_ready, flush,
                 input  push_ready, pop_valid, pop_data);
  modport store (input  push_valid, push_data, pop_ready, flush,
                 output push_ready, pop_valid, pop_data);
endinterface

// file: verilog/byte_fifo.sv
// Show-ahead FIFO holding prefetched boot data.
// Assumes a synchronous flush and a DEPTH that is a power of two.
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_resetn,
  byte_fifo_if.store      fifo
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0]      wr_ptr_ff;
  logic [AW:0]      rd_ptr_ff;
  logic             full;
  logic             empty;

  // =====================================================================
  // Flags
  // The extra pointer bit tells a full ring from an empty one.
  assign empty           = (wr_ptr_ff == rd_ptr_ff);
  assign full            = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                           (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
  assign fifo.push_ready = !full;
  assign fifo.pop_valid  = !empty;
  assign fifo.pop_data   = mem_ff[rd_ptr_ff[AW-1:0]];

  // Storage is written only on an accepted push.
  always_ff @(posedge i_ref_clk) begin
    if (fifo.push_valid && !full) begin
      mem_ff[wr_ptr_ff[AW-1:0]] <= fifo.push_data;
    end
  end

  // Pointers; flush empties the ring in one cycle.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else if (fifo.flush) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (fifo.push_valid && !full) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (fifo.pop_ready && !empty) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
    end
  end

  a_no_overrun: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    full && !fifo.pop_ready && !fifo.flush |=> full)
    else $error("FIFO lost its full state without a pop.");
endmodule

// file: verilog/boot_stream_ctrl.sv
// Serial command logic: boot streaming, boot config register, sector relock.
// Assumes host pins synchronous to i_ref_clk; flash array and NV cell outside.
`timescale 1ns/1ps
`include "boot_stream_map.svh"
module boot_stream_ctrl import boot_stream_pkg::*; #(
  parameter int unsigned WR_CYCLES  = (`CFG_WR_TIME_NS + `CLK_PERIOD_NS - 1) /
                                      `CLK_PERIOD_NS,
  parameter logic [4:0]  FAST_DUMMY = 5'h08,
  parameter logic [4:0]  QUAD_DUMMY = 5'h06,
  parameter int          FIFO_DEPTH = 16
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_cmd_reset,
  input  wire logic        i_cs_n,
  input  wire logic        i_sck,
  input  wire logic        i_si,
  input  wire logic        i_quad_io_enable,
  output logic [3:0]       o_io_out,
  output logic [3:0]       o_io_oe,
  input  wire logic [31:0] i_nv_cfg,
  output logic             o_nv_wr,
  output logic [31:0]      o_nv_cfg,
  output logic [23:0]      o_mem_addr,
  output logic             o_mem_ready,
  input  wire logic        i_mem_valid,
  input  wire logic [7:0]  i_mem_data,
  input  wire logic [23:0] i_chk_addr,
  input  wire logic        i_chk_in_prot_block,
  output logic             o_chk_prog_ok,
  output logic             o_write_in_progress,
  output logic             o_write_enable_latch,
  output logic             o_boot_active
);
  state_e      state_ff;
  state_e      nxt_state;
  logic        sck_q_ff;
  logic [5:0]  cnt_ff;
  logic [6:0]  cmd_sh_ff;
  logic [22:0] unp_sh_ff;
  cfg_t        cfg_ff;
  cfg_t        wr_buf_ff;
  logic [7:0]  out_sh_ff;
  logic [2:0]  out_pos_ff;
  logic [4:0]  out_cnt_ff;
  logic        quad_ff;
  logic        armed_ff;
  logic        started_ff;
  logic        done_ff;
  logic        wip_ff;
  logic        wel_ff;
  logic [15:0] tmr_ff;
  logic        unp_valid_ff;
  logic [11:0] unp_sector_ff;
  logic        rise;
  logic        fall;
  logic        decode;
  logic [7:0]  opcode;
  logic [7:0]  status;
  logic [4:0]  dly_len;
  logic        wr_start;
  logic        wr_done;
  logic        boot_end;
  logic        boot_abort;

  byte_fifo_if #(.WIDTH(8)) fq ();

  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .fifo      (fq)
  );

  // Bit position inside the register for serial bit k: low byte first, MSB first.
  function automatic logic [4:0] cfg_bit_idx(input logic [4:0] k);
    cfg_bit_idx = {k[4:3], ~k[2:0]};
  endfunction

  // Lanes driven for one step of a boot byte in single or quad width.
  function automatic logic [3:0] emit(input logic [7:0] b, input logic [2:0] pos,
                                     input logic quad);
    if (quad) begin
      emit = (pos == 3'h0) ? b[7:4] : b[3:0];
    end else begin
      emit = {2'b00, b[~pos], 1'b0};
    end
  endfunction

  // =====================================================================
  // Serial clock edges and decode
  // Pins are synchronous, so a single delay stage is enough for edge detection.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sck_q_ff <= 1'b0;
    end else begin
      sck_q_ff <= i_sck;
    end
  end

  assign rise   = !i_cs_n && i_sck && !sck_q_ff;
  assign fall   = !i_cs_n && !i_sck && sck_q_ff;
  assign opcode = {cmd_sh_ff, i_si};
  assign decode = (state_ff == ST_CMD) && rise && (cnt_ff == 6'h07);

  // Delay field wins; a zero field falls back to the active read's dummy count.
  assign dly_len = (cfg_ff[`CFG_DLY_MSB:`CFG_DLY_LSB] != 4'h0) ?
                   {1'b0, cfg_ff[`CFG_DLY_MSB:`CFG_DLY_LSB]} :
                   (quad_ff ? QUAD_DUMMY : FAST_DUMMY);

  always_comb begin
    status              = 8'h00;
    status[`SR_WIP_BIT] = wip_ff;
    status[`SR_WEL_BIT] = wel_ff;
    status[`SR_QE_BIT]  = i_quad_io_enable;
  end

  // =====================================================================
  // Frame state machine
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_ff <= ST_LOAD;
    end else if (i_cmd_reset) begin
      state_ff <= ST_LOAD;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_LOAD: nxt_state = ST_IDLE;
      ST_IDLE: begin
        if (!i_cs_n) begin
          nxt_state = armed_ff ? ST_BOOT_DLY : ST_CMD;
        end
      end
      ST_BOOT_DLY: begin
        if (rise && (cnt_ff + 6'h01 >= {1'b0, dly_len})) begin
          nxt_state = ST_BOOT_OUT;
        end
      end
      ST_CMD: begin
        if (decode) begin
          // While a write runs only the status read is honoured.
          if (wip_ff && opcode != `OP_READ_STATUS) begin
            nxt_state = ST_SKIP;
          end else if (opcode == `OP_READ_STATUS) begin
            nxt_state = ST_RD_STAT;
          end else if (opcode == `OP_BOOT_CFG_READ) begin
            nxt_state = ST_RD_CFG;
          end else if (opcode == `OP_BOOT_CFG_WRITE) begin
            nxt_state = wel_ff ? ST_WR_CFG : ST_SKIP;
          end else if (opcode == `OP_SECTOR_UNPROT) begin
            nxt_state = ST_UNPROT;
          end else begin
            nxt_state = ST_SKIP;
          end
        end
      end
      ST_UNPROT: begin
        if (rise && cnt_ff == `UNPROT_LAST_BIT) begin
          nxt_state = ST_SKIP;
        end
      end
      ST_BOOT_OUT, ST_RD_CFG, ST_RD_STAT, ST_WR_CFG, ST_SKIP: nxt_state = state_ff;
    endcase
    // Chip select high ends any frame; a finished boot stream drops to command mode.
    if (i_cs_n && state_ff != ST_LOAD) begin
      nxt_state = ST_IDLE;
    end
  end

  // Clock counter inside a frame, restarted after the opcode.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_ff <= 6'h00;
    end else if (state_ff == ST_IDLE || decode) begin
      cnt_ff <= 6'h00;
    end else if (rise && cnt_ff != 6'h3F) begin
      cnt_ff <= cnt_ff + 6'h01;
    end
  end

  // =====================================================================
  // Inbound shifters: opcode, config write data, unprotect address
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cmd_sh_ff <= 7'h00;
      wr_buf_ff <= `CFG_RESET;
      unp_sh_ff <= 23'h000000;
    end else if (rise) begin
      cmd_sh_ff <= {cmd_sh_ff[5:0], i_si};
      unp_sh_ff <= {unp_sh_ff[21:0], i_si};
      if (state_ff == ST_WR_CFG && cnt_ff < `CFG_BITS) begin
        wr_buf_ff[cfg_bit_idx(cnt_ff[4:0])] <= i_si;
      end
    end
  end

  // =====================================================================
  // Outbound lanes, changed on the falling clock edge
  assign fq.pop_ready = fall && (state_ff == ST_BOOT_OUT) && (out_pos_ff == 3'h0);

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_io_out   <= 4'h0;
      o_io_oe    <= 4'h0;
      out_sh_ff  <= 8'h00;
      out_pos_ff <= 3'h0;
      out_cnt_ff <= 5'h00;
    end else if (i_cs_n || state_ff == ST_IDLE) begin
      o_io_oe    <= 4'h0;
      out_pos_ff <= 3'h0;
      out_cnt_ff <= 5'h00;
    end else if (fall) begin
      if (state_ff == ST_RD_CFG) begin
        // Counter wraps after 32 bits, so the register repeats.
        o_io_out   <= {2'b00, cfg_ff[cfg_bit_idx(out_cnt_ff)], 1'b0};
        o_io_oe    <= 4'h2;
        out_cnt_ff <= out_cnt_ff + 5'h01;
      end else if (state_ff == ST_RD_STAT) begin
        o_io_out   <= {2'b00, status[~out_cnt_ff[2:0]], 1'b0};
        o_io_oe    <= 4'h2;
        out_cnt_ff <= out_cnt_ff + 5'h01;
      end else if (state_ff == ST_BOOT_OUT) begin
        if (out_pos_ff == 3'h0) begin
          out_sh_ff <= fq.pop_data;
          o_io_out  <= emit(fq.pop_data, out_pos_ff, quad_ff);
        end else begin
          o_io_out  <= emit(out_sh_ff, out_pos_ff, quad_ff);
        end
        o_io_oe    <= quad_ff ? 4'hF : 4'h2;
        out_pos_ff <= out_pos_ff + (quad_ff ? 3'h4 : 3'h1);
      end
    end
  end

  // =====================================================================
  // Boot arming and stream bookkeeping
  assign boot_end   = i_cs_n && (state_ff == ST_BOOT_OUT) && done_ff;
  assign boot_abort = i_cs_n && !done_ff &&
                      (state_ff == ST_BOOT_DLY || state_ff == ST_BOOT_OUT);
  assign fq.flush   = boot_end || boot_abort || (state_ff == ST_LOAD);

  // The enable bit is caught after reset release, not by the reset itself.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      armed_ff <= 1'b0;
      quad_ff  <= 1'b0;
    end else begin
      if (state_ff == ST_LOAD) begin
        armed_ff <= i_nv_cfg[`CFG_EN_BIT];
      end else if (boot_end) begin
        armed_ff <= 1'b0;
      end
      if (state_ff == ST_IDLE) begin
        quad_ff <= i_quad_io_enable;
      end
    end
  end

  // A byte counts as sent on the rising edge that samples its last bits.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      started_ff <= 1'b0;
      done_ff    <= 1'b0;
    end else if (state_ff == ST_IDLE) begin
      started_ff <= 1'b0;
      done_ff    <= 1'b0;
    end else begin
      if (fq.pop_ready) begin
        started_ff <= 1'b1;
      end
      if (rise && state_ff == ST_BOOT_OUT && out_pos_ff == 3'h0 && started_ff) begin
        done_ff <= 1'b1;
      end
    end
  end

  // =====================================================================
  // Boot data prefetch from the array into the FIFO
  // An aborted frame rewinds the prefetch so the next try starts clean.
  assign fq.push_valid = i_mem_valid && armed_ff && !fq.flush;
  assign fq.push_data  = i_mem_data;
  assign o_mem_ready   = fq.push_ready && armed_ff && !fq.flush;
  assign o_boot_active = armed_ff;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_mem_addr <= 24'h000000;
    end else if (state_ff == ST_LOAD) begin
      o_mem_addr <= i_nv_cfg[`CFG_ADDR_MSB:`CFG_ADDR_LSB];
    end else if (boot_abort) begin
      o_mem_addr <= cfg_ff[`CFG_ADDR_MSB:`CFG_ADDR_LSB];
    end else if (fq.push_valid && fq.push_ready) begin
      o_mem_addr <= o_mem_addr + 24'h000001;
    end
  end

  // =====================================================================
  // Config write engine, latch and non-volatile update
  assign wr_start = i_cs_n && (state_ff == ST_WR_CFG) && (cnt_ff == `CFG_BITS);
  assign wr_done  = wip_ff && (tmr_ff == 16'h0000);

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wip_ff <= 1'b0;
      tmr_ff <= 16'h0000;
    end else if (wr_start) begin
      wip_ff <= 1'b1;
      tmr_ff <= 16'(WR_CYCLES - 1);
    end else if (wr_done) begin
      wip_ff <= 1'b0;
    end else if (wip_ff) begin
      tmr_ff <= tmr_ff - 16'h0001;
    end
  end

  // Set wins over clear, although a write enable is refused while busy.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wel_ff <= 1'b0;
    end else if (decode && !wip_ff && opcode == `OP_WRITE_ENABLE) begin
      wel_ff <= 1'b1;
    end else if (wr_done) begin
      wel_ff <= 1'b0;
    end
  end

  // Working copy reloads from the NV cell on every reset.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_ff   <= `CFG_RESET;
      o_nv_wr  <= 1'b0;
      o_nv_cfg <= `CFG_RESET;
    end else begin
      o_nv_wr <= wr_done;
      if (state_ff == ST_LOAD) begin
        cfg_ff <= i_nv_cfg;
      end else if (wr_done) begin
        cfg_ff   <= wr_buf_ff;
        o_nv_cfg <= wr_buf_ff;
      end
    end
  end

  assign o_write_in_progress  = wip_ff;
  assign o_write_enable_latch = wel_ff;

  // =====================================================================
  // Single unprotected sector and program permission
  // A second unprotect is ignored until the first sector is relocked.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      unp_valid_ff  <= 1'b0;
      unp_sector_ff <= 12'h000;
    end else if (decode && !wip_ff && opcode == `OP_SECTOR_RELOCK) begin
      unp_valid_ff <= 1'b0;
    end else if (state_ff == ST_UNPROT && rise && cnt_ff == `UNPROT_LAST_BIT &&
                 !unp_valid_ff) begin
      unp_valid_ff  <= 1'b1;
      unp_sector_ff <= unp_sh_ff[22:`SECTOR_LSB-1];
    end
  end

  // Reads are never gated; only program and erase depend on the sector.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_chk_prog_ok <= 1'b0;
    end else begin
      o_chk_prog_ok <= !i_chk_in_prot_block || (unp_valid_ff &&
                       i_chk_addr[23:`SECTOR_LSB] == unp_sector_ff);
    end
  end

  // =====================================================================
  // Assertions
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  a_relock_clears: assert property (
    decode && !wip_ff && opcode == `OP_SECTOR_RELOCK |=> !unp_valid_ff)
    else $error("Relock left a sector unprotected.");
  a_prot_gate: assert property (
    i_chk_in_prot_block && !unp_valid_ff |=> !o_chk_prog_ok)
    else $error("Protected sector reported programmable.");
  a_delay_quiet: assert property (
    state_ff == ST_BOOT_DLY |-> o_io_oe == 4'h0)
    else $error("Lanes driven during boot delay.");
  a_load_arm: assert property (
    state_ff == ST_LOAD |=> armed_ff == $past(i_nv_cfg[`CFG_EN_BIT]))
    else $error("Boot arming does not follow enable bit.");
  a_wr_reject: assert property (
    decode && opcode == `OP_BOOT_CFG_WRITE && !wel_ff |=> state_ff != ST_WR_CFG)
    else $error("Config write accepted without latch.");
  a_wip_span: assert property (
    wr_start |=> wip_ff [*8])
    else $error("Write in progress dropped early.");
  a_done_clear: assert property (
    wr_done |=> !wel_ff && !wip_ff && o_nv_wr)
    else $error("Write completion did not clear status.");
  a_addr_step: assert property (
    fq.push_valid && fq.push_ready |=> o_mem_addr == $past(o_mem_addr) + 24'h000001)
    else $error("Boot address did not advance by one.");
  a_boot_once: assert property (
    boot_end |=> !armed_ff ##1 !armed_ff)
    else $error("Boot stream re-armed without reset.");
  a_cfg_bit: assert property (
    state_ff == ST_RD_CFG && fall && !i_cs_n |=>
      o_io_out[1] == $past(cfg_ff[cfg_bit_idx(out_cnt_ff)]))
    else $error("Config read bit out of order.");

  c_boot_stream: cover property (boot_end);
  c_cfg_write: cover property (wr_done);
  c_relock: cover property (decode && opcode == `OP_SECTOR_RELOCK && unp_valid_ff);
  c_status_busy: cover property (state_ff == ST_RD_STAT && wip_ff && fall);
endmodule

// file: bench/host_model.sv
// Host side of the serial link: chip select, serial clock and data in.
// Assumes the block samples sck on i_ref_clk, so each phase spans 3 clocks.
`timescale 1ns/1ps
module host_model (
  input  wire logic       i_ref_clk,
  input  wire logic [3:0] i_io,
  output logic            o_cs_n,
  output logic            o_sck,
  output logic            o_si
);
  // Single-line data collects lane 1; quad data collects all four lanes.
  logic [63:0] rx;
  logic [63:0] rxq;
  // ==================================================================
  // Idle state.
  // Mode 0: the clock rests low between frames.
  initial begin
    o_cs_n = 1'b1;
    o_sck  = 1'b0;
    o_si   = 1'b0;
    rx     = '0;
    rxq    = '0;
  end
  // ==================================================================
  // Frames.
  // Data is sampled at the end of the low phase, where it has settled.
  task automatic xfer(input logic b);
    o_sck = 1'b0;
    o_si  = b;
    repeat (3) @(posedge i_ref_clk);
    #1;
    rx    = {rx[62:0], i_io[1]};
    rxq   = {rxq[59:0], i_io};
    o_sck = 1'b1;
    repeat (3) @(posedge i_ref_clk);
    #1;
  endtask
  // Sends n bits MSB first from tx, then raises chip select after the last rise.
  task automatic frame(input logic [63:0] tx, input int n);
    @(posedge i_ref_clk);
    #1;
    o_cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      xfer(tx[63-i]);
    end
    o_cs_n = 1'b1;
    repeat (3) @(posedge i_ref_clk);
    #1;
    o_sck  = 1'b0;
    o_si   = ~o_si; // Released line: never leave the last bit showing.
  endtask
endmodule

// file: bench/tb_top.sv
// Self-checking bench for the boot stream and boot config commands.
// Assumes host_model as the far side and a memory that returns address low bytes.
`timescale 1ns/1ps
`include "boot_stream_map.svh"
`define CHK(n, e, v) begin cmp_count++; if ((v) !== (e)) begin miscompares++; \
  $display("wrong value %s expected %h seen %h", n, e, v); end end
module tb_top import boot_stream_pkg::*;;
  localparam cfg_t BOOT_CFG = 32'h0000_1007;
  localparam cfg_t NEW_CFG  = 32'h1234_5601;
  logic        clk = 1'b0;
  logic        resetn;
  logic        cs_n, sck, si, nv_wr, mem_ready, write_in_progress, write_enable_latch, active, prog_ok;
  logic        qe = 1'b0;
  logic        cmd_reset = 1'b0;
  logic        in_prot = 1'b0;
  logic [23:0] chk_addr = 24'h00_0000;
  logic [3:0]  io_out, io_oe;
  cfg_t        nv_cfg;
  logic [23:0] mem_addr;
  int          miscompares = 0;
  int          cmp_count = 0;
  // ==================================================================
  // Clock, far side and design.
  always #25 clk = ~clk;
  // An undriven lane reads as the inverse of its last value, so a missing enable shows.
  host_model i_host_model (.i_ref_clk(clk), .i_io(io_out ~^ io_oe), .o_cs_n(cs_n),
    .o_sck(sck), .o_si(si));
  // Memory answers at once with the low address byte, so boot data is predictable.
  // The write time is long enough for a status read to see the write still running.
  boot_stream_ctrl #(.WR_CYCLES(200)) i_boot_stream_ctrl (.i_ref_clk(clk), .i_resetn(resetn),
    .i_cmd_reset(cmd_reset), .i_cs_n(cs_n), .i_sck(sck), .i_si(si), .i_quad_io_enable(qe),
    .o_io_out(io_out), .o_io_oe(io_oe), .i_nv_cfg(BOOT_CFG), .o_nv_wr(nv_wr),
    .o_nv_cfg(nv_cfg), .o_mem_addr(mem_addr), .o_mem_ready(mem_ready), .i_mem_valid(1'b1),
    .i_mem_data(mem_addr[7:0]), .i_chk_addr(chk_addr), .i_chk_in_prot_block(in_prot),
    .o_chk_prog_ok(prog_ok), .o_write_in_progress(write_in_progress), .o_write_enable_latch(write_enable_latch),
    .o_boot_active(active));
  // ==================================================================
  // Helpers.
  function automatic logic [31:0] lsbf(input cfg_t c);
    return {c[7:0], c[15:8], c[23:16], c[31:24]};
  endfunction
  task automatic print_verdict;
    if (miscompares == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ==================================================================
  // Scenarios.
  // No opcode: 3 delay rises, then two bytes from the start address.
  task automatic t_boot;
    i_host_model.frame(64'h0, 19);
    `CHK("boot bytes", 16'h1011, i_host_model.rx[15:0]);
    `CHK("armed after stream", 1'b0, active);
    `CHK("fetch stopped", 1'b0, mem_ready);
  endtask
  // Two full groups prove the register repeats.
  task automatic t_cfg_read;
    i_host_model.frame({`OP_BOOT_CFG_READ, 56'h0}, 72);
    `CHK("cfg read", {lsbf(BOOT_CFG), lsbf(BOOT_CFG)}, i_host_model.rx);
  endtask
  // Refused without latch, discarded at 33 bits, taken at exactly 32.
  task automatic t_cfg_write;
    int n;
    i_host_model.frame({`OP_BOOT_CFG_WRITE, lsbf(NEW_CFG), 24'h0}, 40);
    `CHK("busy without latch", 1'b0, write_in_progress);
    i_host_model.frame({`OP_WRITE_ENABLE, 56'h0}, 8);
    `CHK("latch", 1'b1, write_enable_latch);
    i_host_model.frame({`OP_BOOT_CFG_WRITE, lsbf(NEW_CFG), 24'h0}, 41);
    `CHK("busy after 33 bits", 1'b0, write_in_progress);
    i_host_model.frame({`OP_WRITE_ENABLE, 56'h0}, 8);
    i_host_model.frame({`OP_BOOT_CFG_WRITE, lsbf(NEW_CFG), 24'h0}, 40);
    `CHK("busy", 1'b1, write_in_progress);
    i_host_model.frame({`OP_READ_STATUS, 56'h0}, 16);
    `CHK("status busy", 8'h03, i_host_model.rx[7:0]);
    n = 0;
    while (nv_wr !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 400) begin
      miscompares++;
      print_verdict();
    end
    `CHK("stored cfg", NEW_CFG, nv_cfg);
    @(posedge clk);
    #1;
    `CHK("busy done", 1'b0, write_in_progress);
    `CHK("latch done", 1'b0, write_enable_latch);
  endtask
  // Unprotect one sector, look at its neighbour, then relock it.
  task automatic t_sector;
    in_prot  = 1'b1;
    chk_addr = 24'h00_5123;
    i_host_model.frame({`OP_SECTOR_UNPROT, 24'h00_5ABC, 32'h0}, 32);
    `CHK("unprotected sector", 1'b1, prog_ok);
    chk_addr = 24'h00_6123;
    repeat (2) @(posedge clk);
    #1;
    `CHK("neighbour sector", 1'b0, prog_ok);
    chk_addr = 24'h00_5123;
    i_host_model.frame({`OP_SECTOR_RELOCK, 56'h0}, 8);
    `CHK("relocked sector", 1'b0, prog_ok);
  endtask
  // Command reset re-arms the stream; quad lanes carry one nibble per clock.
  task automatic t_quad;
    qe        = 1'b1;
    cmd_reset = 1'b1;
    @(posedge clk);
    #1;
    cmd_reset = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    `CHK("re-armed", 1'b1, active);
    i_host_model.frame(64'h0, 7);
    `CHK("quad bytes", 16'h1011, i_host_model.rxq[15:0]);
    `CHK("quad stream ended", 1'b0, active);
  endtask
  // ==================================================================
  // Main sequence.
  initial begin
    resetn = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    resetn = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    `CHK("armed", 1'b1, active);
    t_boot();
    t_cfg_read();
    t_cfg_write();
    t_sector();
    t_quad();
    print_verdict();
  end
endmodule
